// *** bench/pch_config_header_checker.sv ***
// Assertions on the configuration header bank ports.
// Assumes it is bound into pch_config_header and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pch_config_header_checker (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire pch_pkg::pch_cfg_req_t cfgReq,
  input wire pch_pkg::pch_cfg_rsp_t cfgRsp,
  input wire pch_pkg::pch_evt_t     busEvt,
  input wire logic                  systemErrorLineOe,
  input wire logic                  parityErrorLineOe,
  input wire logic                  busRequest,
  input wire logic                  memClaim,
  input wire logic                  useWriteInvalidate,
  input wire logic                  masterDataParityFlag,
  input wire logic [15:0]           busCommandControl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ack_func: assert property ((cfgReq.rd | cfgReq.wr) |=>
    cfgRsp.ack == $past(cfgReq.func == 3'h0)) else $error("ack mismatch");
  a_id_read: assert property (cfgReq.rd && cfgReq.func == 3'h0 &&
    cfgReq.addr[7:2] == 6'h0 |=> cfgRsp.rdata ==
    {pch_pkg::PART_ID_VAL, pch_pkg::MAKER_ID_VAL}) else $error("id value");
  a_cmd_fixed: assert property (
    (busCommandControl & 16'hfea9) == 16'h0) else $error("fixed bit set");
  a_serr_gate: assert property (systemErrorLineOe ==
    $past(busCommandControl[8] & busEvt.addrParErr)) else $error("serr");
  a_perr_gate: assert property (parityErrorLineOe ==
    $past(busCommandControl[6] & busEvt.dataParErr)) else $error("perr");
  a_flag_enable: assert property ($rose(masterDataParityFlag) |->
    $past(busCommandControl[6])) else $error("parity flag without enable");
  a_inval_follow: assert property (useWriteInvalidate ==
    $past(busCommandControl[4] & busEvt.writeInvalReq)) else $error("mwi");
  a_req_follow: assert property (busRequest ==
    $past(busCommandControl[2] & busEvt.masterReq)) else $error("request");
  a_claim_follow: assert property (memClaim ==
    $past(busCommandControl[1] & busEvt.memCycle)) else $error("claim");
  c_write: cover property (cfgReq.wr && cfgReq.func == 3'h0);
  c_claim: cover property (memClaim);
  c_req: cover property (busRequest && useWriteInvalidate);
  c_flag: cover property ($rose(masterDataParityFlag));
endmodule : pch_config_header_checker
bind pch_config_header pch_config_header_checker u_pch_config_header_checker (
  .clk, .rstn, .cfgReq, .cfgRsp, .busEvt, .systemErrorLineOe,
  .parityErrorLineOe, .busRequest, .memClaim, .useWriteInvalidate,
  .masterDataParityFlag, .busCommandControl);
`default_nettype wire

// *** bench/pch_host_model.sv ***
// Host bridge model issuing configuration cycles.
// Assumes ack is registered on the taking edge, one cycle after the request is driven.
`timescale 1ns/1ps
`default_nettype none
module pch_host_model (
  input  wire logic                  clk,
  input  wire pch_pkg::pch_cfg_rsp_t cfgRsp,
  output var  pch_pkg::pch_cfg_req_t cfgReq
);
  initial cfgReq = '0;
  task automatic access(input logic wr, input logic [2:0] fn,
      input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd,
      output logic ack, output logic [31:0] rd);
    @(posedge clk);
    #1;
    cfgReq = '{rd: !wr, wr: wr, func: fn, addr: ad, byteEn: be, wdata: wd};
    @(posedge clk);
    #1;
    cfgReq.rd = 1'b0;
    cfgReq.wr = 1'b0;
    // Released data toggles so a stale value cannot pass unnoticed
    cfgReq.wdata = ~wd;
    ack = cfgRsp.ack;
    rd = cfgRsp.rdata;
  endtask : access
endmodule : pch_host_model
`default_nettype wire

// *** bench/tb_pch_config_header.sv ***
// Self-checking bench for the configuration header bank.
// Assumes the host model drives every configuration cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin \
  errCount++; $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module tb_pch_config_header;
  logic clk, rstn, pinIn, ack, flag;
  logic systemErrorLineOe, parityErrorLineOe, busRequest, memClaim;
  logic useWriteInvalidate, masterDataParityFlag, vendorAccess;
  logic [15:0] busCommandControl, mdl;
  logic [31:0] rd, wd;
  logic [3:0] be;
  int errCount, numChecks;
  pch_pkg::pch_cfg_req_t cfgReq;
  pch_pkg::pch_cfg_rsp_t cfgRsp;
  pch_pkg::pch_evt_t busEvt;
  pch_config_header u_pch_config_header (.clk, .rstn, .cfgReq, .cfgRsp,
    .parityErrorLineIn(pinIn), .busEvt, .systemErrorLineOe,
    .parityErrorLineOe, .busRequest, .memClaim, .useWriteInvalidate,
    .masterDataParityFlag, .vendorAccess, .busCommandControl);
  pch_host_model u_pch_host_model (.clk, .cfgRsp, .cfgReq);
  task automatic cfg(input logic w, input logic [7:0] a,
      input logic [3:0] b, input logic [31:0] d);
    u_pch_host_model.access(w, 3'h0, a, b, d, ack, rd);
    `CHK("ack", 1'b1, ack)
    `CHK("vendor", a >= 8'h40, vendorAccess)
    if (w && a[7:2] == 6'h1) begin
      if (b[0]) mdl[7:0] = d[7:0] & 8'h56;
      if (b[1]) mdl[15:8] = d[15:8] & 8'h01;
      if (b[3] && d[24]) flag = 1'b0;
    end
  endtask : cfg
  task automatic chkCmd();
    cfg(1'b0, 8'h04, 4'hf, 32'h0);
    `CHK("command", mdl, rd[15:0])
    `CHK("cmdPort", mdl, busCommandControl)
    `CHK("status", {7'h0, flag, 8'h0}, rd[31:16])
  endtask : chkCmd
  // Parity pin path: three sync stages, the agreement filter and the flag register
  task automatic pinPerr();
    @(posedge clk);
    #1 pinIn = 1'b1;
    busEvt.masterPhase = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    if (mdl[6]) flag = 1'b1;
    `CHK("dparPin", flag, masterDataParityFlag)
    pinIn = 1'b0;
    busEvt = '0;
    repeat (4) @(posedge clk);
  endtask : pinPerr
  // Random events cover every enable with its command bit both ways
  task automatic evts();
    @(posedge clk);
    #1 busEvt = 7'($urandom);
    @(posedge clk);
    #1;
    if (busEvt.perrSeen && busEvt.masterPhase && mdl[6]) flag = 1'b1;
    `CHK("busReq", mdl[2] & busEvt.masterReq, busRequest)
    `CHK("claim", mdl[1] & busEvt.memCycle, memClaim)
    `CHK("mwi", mdl[4] & busEvt.writeInvalReq, useWriteInvalidate)
    `CHK("serr", mdl[8] & busEvt.addrParErr, systemErrorLineOe)
    `CHK("perr", mdl[6] & busEvt.dataParErr, parityErrorLineOe)
    `CHK("dpar", flag, masterDataParityFlag)
    busEvt = '0;
  endtask : evts
  task automatic end_of_test();
    $display("Checks: %0d, errors: %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    errCount++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    pinIn = 1'b0;
    busEvt = '0;
    mdl = 16'h0;
    flag = 1'b0;
    void'($urandom(32'hb2f6));
    repeat (4) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge clk);
    chkCmd();
    cfg(1'b0, 8'h00, 4'hf, 32'h0);
    `CHK("ids", {pch_pkg::PART_ID_VAL, pch_pkg::MAKER_ID_VAL}, rd)
    cfg(1'b1, 8'h00, 4'hf, 32'hffffffff);
    cfg(1'b1, 8'h04, 4'h3, 32'h0000ffff);
    cfg(1'b0, 8'h00, 4'hf, 32'h0);
    `CHK("idsKept", {pch_pkg::PART_ID_VAL, pch_pkg::MAKER_ID_VAL}, rd)
    chkCmd();
    u_pch_host_model.access(1'b1, 3'h1, 8'h04, 4'hf, 32'h0, ack, rd);
    `CHK("otherFunc", 1'b0, ack)
    chkCmd();
    cfg(1'b0, 8'h40, 4'hf, 32'h0);
    `CHK("vendorRd", 32'h0, rd)
    repeat (24) begin
      wd = $urandom;
      be = 4'($urandom);
      cfg(1'b1, 8'h04, be, wd);
      chkCmd();
      evts();
      pinPerr();
    end
    rstn = 1'b0;
    mdl = 16'h0;
    flag = 1'b0;
    @(posedge clk);
    #1 rstn = 1'b1;
    repeat (2) @(posedge clk);
    chkCmd();
    end_of_test();
  end
endmodule : tb_pch_config_header
`default_nettype wire

// *** rtl/pch_config_header.sv ***
// Configuration header bank: identification, command register and the
// enables that the command bits place on the bus side of the device.
// Assumes the bus logic presents one decoded configuration access per
// cycle and reports bus events on the same clock; the parity error pin
// arrives asynchronously and is synchronised here.
//
// Notes on behaviour
// R1 - Single function: only function zero answers configuration accesses.
// R2 - Maker identification at offset 0 is fixed and ignores writes.
// R3 - Part identification at offset 2 is fixed and read-only.
// R4 - Sixteen-bit command register at offset 4, cleared by reset.
// R5 - Command bits 15 to 10 always read zero.
// R6 - Command bit 9 reads zero; no fast back-to-back generation.
// R7 - System error line driven only with bit 8 set, on address parity.
// R8 - Command bit 7 held zero; no address or data stepping.
// R9 - Parity error line driven only while bit 6 is set.
// R10 - Command bit 5 reads zero; no palette snooping.
// R11 - Write-and-invalidate used only with bit 4 set, else plain write.
// R12 - Special cycles ignored; command bit 3 reads zero.
// R13 - Bus requests as initiator only while bit 2 is set.
// R14 - Memory cycles claimed only while bit 1 set; software sets it first.
// R15 - No I/O decode; command bit 0 reads zero.
// R16 - Vendor registers occupy offsets 40h through FCh after the header.
// R17 - Data parity flag needs parity line, master phase and bit 6 set.
// R18 - Writes to hardwired command and identification bits are dropped.
`timescale 1ns/1ps
`default_nettype none
module pch_config_header (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire pch_pkg::pch_cfg_req_t cfgReq,
  output var  pch_pkg::pch_cfg_rsp_t cfgRsp,
  input  wire logic                  parityErrorLineIn,
  input  wire pch_pkg::pch_evt_t     busEvt,
  output var  logic                  systemErrorLineOe,
  output var  logic                  parityErrorLineOe,
  output var  logic                  busRequest,
  output var  logic                  memClaim,
  output var  logic                  useWriteInvalidate,
  output var  logic                  masterDataParityFlag,
  output var  logic                  vendorAccess,
  output var  logic [15:0]           busCommandControl
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_r;
  logic rstSyncN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_r <= 1'b0;
      rstSyncN  <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncN  <= rstMeta_r;
    end
  end

  // ----------------------------------------
  // Parity error pin synchroniser
  // ----------------------------------------
  logic perrPinLevel;

  pch_sync u_perrSync (
    .clk      (clk),
    .rstSyncN (rstSyncN),
    .pinIn    (parityErrorLineIn),
    .levelOut (perrPinLevel)
  );

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] cmd;
    logic        ack;
    logic [31:0] rdata;
    logic        serrOe;
    logic        perrOe;
    logic        busReq;
    logic        memClaim;
    logic        mwi;
    logic        master_data_parity_flag;
    logic        vendor;
  } pch_state_t;

  pch_state_t st_r;
  pch_state_t st_nxt;

  // Merge bytes of a write into the writable command bits only
  function automatic logic [15:0] pch_cmd_merge(
    input logic [15:0] cur,
    input logic [15:0] wdata,
    input logic [1:0]  be
  );
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & pch_pkg::CMD_WR_MASK;
    return (cur & ~lane) | (wdata & lane);
  endfunction : pch_cmd_merge

  function automatic logic pch_addr_is(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr[7:2] == off[7:2];
  endfunction : pch_addr_is

  logic        funcHit;
  logic [15:0] statusWord;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;
    // Other functions never answer, so the host sees a master abort
    funcHit    = cfgReq.func == pch_pkg::FUNC_ZERO; // R1
    statusWord = '0;
    statusWord[pch_pkg::STS_DATA_PAR] = st_r.master_data_parity_flag;

    if (funcHit && cfgReq.rd) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = '0;
      if (pch_addr_is(cfgReq.addr, pch_pkg::OFF_MAKER_ID)) begin
        st_nxt.rdata = {pch_pkg::PART_ID_VAL,
                        pch_pkg::MAKER_ID_VAL}; // R2 R3
      end else if (pch_addr_is(cfgReq.addr, pch_pkg::OFF_CMD)) begin
        // Hardwired bits read zero because they can never be stored
        st_nxt.rdata = {statusWord,
                        st_r.cmd & pch_pkg::CMD_WR_MASK}; // R5 R6 R8 R10
      end
    end

    if (funcHit && cfgReq.wr) begin
      st_nxt.ack = 1'b1;
      if (pch_addr_is(cfgReq.addr, pch_pkg::OFF_CMD)) begin
        st_nxt.cmd = pch_cmd_merge(st_r.cmd, cfgReq.wdata[15:0],
                                   cfgReq.byteEn[1:0]); // R18
        // Status half: write one clears, but a new event wins below
        if (cfgReq.byteEn[3] && cfgReq.wdata[16 + pch_pkg::STS_DATA_PAR]) begin
          st_nxt.master_data_parity_flag = 1'b0;
        end
      end
      // Identification writes fall through untouched
    end

    // Vendor-defined window above the standard header
    st_nxt.vendor = funcHit && (cfgReq.rd || cfgReq.wr) &&
                    cfgReq.addr >= pch_pkg::OFF_VENDOR_LO; // R16

    st_nxt.serrOe = st_r.cmd[pch_pkg::CMD_SYS_ERR] &&
                    busEvt.addrParErr; // R7
    st_nxt.perrOe = st_r.cmd[pch_pkg::CMD_PARITY_RESP] &&
                    busEvt.dataParErr; // R9
    st_nxt.mwi    = st_r.cmd[pch_pkg::CMD_WR_INVAL] &&
                    busEvt.writeInvalReq; // R11
    st_nxt.busReq = st_r.cmd[pch_pkg::CMD_INITIATOR] &&
                    busEvt.masterReq; // R13
    // Special cycles and I/O cycles are never claimed
    st_nxt.memClaim = st_r.cmd[pch_pkg::CMD_MEM_SPACE] &&
                      busEvt.memCycle; // R12 R14 R15

    if ((perrPinLevel || busEvt.perrSeen) && busEvt.masterPhase &&
        st_r.cmd[pch_pkg::CMD_PARITY_RESP]) begin
      st_nxt.master_data_parity_flag = 1'b1; // R17
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r     <= '0;
      st_r.cmd <= pch_pkg::CMD_RESET; // R4
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign cfgRsp.ack           = st_r.ack;
  assign cfgRsp.rdata         = st_r.rdata;
  assign systemErrorLineOe    = st_r.serrOe;
  assign parityErrorLineOe    = st_r.perrOe;
  assign busRequest           = st_r.busReq;
  assign memClaim             = st_r.memClaim;
  assign useWriteInvalidate   = st_r.mwi;
  assign masterDataParityFlag = st_r.master_data_parity_flag;
  assign vendorAccess         = st_r.vendor;
  assign busCommandControl    = st_r.cmd;

endmodule : pch_config_header
`default_nettype wire

// *** rtl/pch_pkg.sv ***
// Package for the configuration header command block.
// Assumes a single 200 MHz clock and a configuration access port of
// dword-wide reads and writes with byte enables.
package pch_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_MAKER_ID   = 8'h00;
  localparam logic [7:0] OFF_PART_ID    = 8'h02;
  localparam logic [7:0] OFF_CMD        = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h06;
  localparam logic [7:0] OFF_VENDOR_LO  = 8'h40;
  localparam logic [7:0] OFF_VENDOR_HI  = 8'hfc;

  // Identification values, arbitrary neutral codes
  localparam logic [15:0] MAKER_ID_VAL  = 16'h1234;
  localparam logic [15:0] PART_ID_VAL   = 16'h5678;

  // ----------------------------------------
  // Command register fields
  // ----------------------------------------
  localparam int CMD_IO_SPACE     = 0;
  localparam int CMD_MEM_SPACE    = 1;
  localparam int CMD_INITIATOR    = 2;
  localparam int CMD_SPECIAL      = 3;
  localparam int CMD_WR_INVAL     = 4;
  localparam int CMD_PALETTE      = 5;
  localparam int CMD_PARITY_RESP  = 6;
  localparam int CMD_STEPPING     = 7;
  localparam int CMD_SYS_ERR      = 8;
  localparam int CMD_BACK_TO_BACK = 9;
  localparam logic [15:0] CMD_WR_MASK = 16'h0156;
  localparam logic [15:0] CMD_RESET   = 16'h0000;

  // Status field position of the master data parity flag
  localparam int STS_DATA_PAR     = 8;
  localparam logic [2:0] FUNC_ZERO = 3'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  func;
    logic [7:0]  addr;
    logic [3:0]  byteEn;
    logic [31:0] wdata;
  } pch_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pch_cfg_rsp_t;

  typedef struct packed {
    logic        addrParErr;
    logic        dataParErr;
    logic        perrSeen;
    logic        masterPhase;
    logic        masterReq;
    logic        memCycle;
    logic        writeInvalReq;
  } pch_evt_t;

endpackage : pch_pkg

// *** rtl/pch_sync.sv ***
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes the async input may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none
module pch_sync (
  input  wire logic clk,
  input  wire logic rstSyncN,
  input  wire logic pinIn,
  output var  logic levelOut
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } pch_sync_st_t;

  pch_sync_st_t st_r;
  pch_sync_st_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Accept a change only once two stable stages agree
    if (st_r.s2 == st_r.s3) begin
      st_nxt.lvl = st_r.s3;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign levelOut = st_r.lvl;

endmodule : pch_sync
`default_nettype wire
